// >>> src/ppc_loader.sv
// Partition and port static configuration block with AXI4-Lite slave.
// Assumes loader writes arrive during fundamental reset sequencing.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ppc_cfg.svh"
module ppc_loader #(
  parameter int NPORTS = 16   // Number of switch ports
) (
  input  wire logic                  clock,          // Core clock
  input  wire logic                  rst_b,          // Async reset, active low
  input  wire logic [3:0]            boot_switch_mode, // Sampled boot mode
  input  wire logic                  fund_reset_active, // Fundamental reset sequence window
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output ppc_pkg::ppc_link_t [NPORTS-1:0] port_link,  // Per-port link control
  output logic [1:0]                 partition_active, // Partition states
  output logic                       partition_reset_input_n_en // Pin alternate function
);
  import ppc_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [31:0]       side_effect_delay_timer;
  logic [31:0]       mode_change_drain_delay_timer;
  logic [31:0]       reset_drain_delay_timer;
  logic [31:0]       upstream_bus_reset_delay_timer;
  ppc_pstate_t       partition0_control;
  ppc_pstate_t       partition1_control;
  ppc_port_t         port_control [NPORTS];
  logic [7:0]        power_mgmt_capability [NPORTS];           // Next pointers
  logic [11:0]       virtual_channel_capability_header [NPORTS];
  logic              gpio_alt;                                 // Pin function enable
  logic              load_done;                                // Software closed load
  logic [NPORTS-1:0] retrain_go;                               // Retrain start pulses
  logic [NPORTS-1:0] retrain_busy;                             // Retrain in progress
  logic [NPORTS-1:0] retrain_det;                              // Port in Detect

  // ----------------------------------------
  // AXI write channel
  // ----------------------------------------
  logic        aw_held;     // Address captured
  logic        w_held;      // Data captured
  logic [11:0] aw_addr;     // Captured address
  logic [31:0] w_data;      // Captured data
  logic [3:0]  w_strb;      // Captured strobes: the bus may move on before both halves meet
  logic        wr_fire;     // Both halves present
  logic        wr_ok;       // Address mapped and window open

  // Port index decode used by writes and reads
  function automatic logic [3:0] port_idx(input logic [11:0] a);
    port_idx = a[5:2];
  endfunction

  // Mapped-address check for reads and writes
  function automatic logic mapped(input logic [11:0] a);
    logic [3:0] hi;
    hi = a[11:8];
    mapped = (a[1:0] == 2'b00) && ((hi == 4'h0 && a[7:0] <= 8'h18) ||
             (hi == 4'h1 && a[7:0] <= 8'h04) ||
             ((hi >= 4'h2 && hi <= 4'h5) && ({2'b00, a[7:2]} < 8'(NPORTS))));
  endfunction

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  // Static setup only while fundamental reset sequencing runs
  assign wr_ok         = mapped(aw_addr) && fund_reset_active && !load_done; // RULE1

  // Capture address and data in either order; answer after both
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 12'h000;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Global registers
  // ----------------------------------------
  // Timers, partitions, pin function; boot mode 0xD leaves partitions and pin function disabled
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      side_effect_delay_timer        <= `PPC_RST_SIDE_DLY;
      mode_change_drain_delay_timer  <= `PPC_RST_MODE_DLY;
      reset_drain_delay_timer        <= `PPC_RST_DRAIN_DLY;
      upstream_bus_reset_delay_timer <= `PPC_RST_USBR_DLY;
      partition0_control             <= PPC_PARTITION_SELECT_DIS; // RULE2
      partition1_control             <= PPC_PARTITION_SELECT_DIS; // RULE2
      gpio_alt                       <= 1'b0;
      load_done                      <= 1'b0;
    end else if (wr_fire && wr_ok && w_strb == 4'hf) begin
      case (aw_addr)
        `PPC_OFS_SIDE_DLY:  side_effect_delay_timer        <= w_data;
        `PPC_OFS_MODE_DLY:  mode_change_drain_delay_timer  <= w_data;
        `PPC_OFS_DRAIN_DLY: reset_drain_delay_timer        <= w_data;
        `PPC_OFS_USBR_DLY:  upstream_bus_reset_delay_timer <= w_data;
        `PPC_OFS_LOAD_CTL:  load_done <= w_data[`PPC_LOAD_DONE_BIT];
        `PPC_OFS_GPIO_ALT:  gpio_alt  <= w_data[0];
        `PPC_OFS_PART0:     partition0_control <= ppc_pstate_t'(w_data[1:0]);
        `PPC_OFS_PART1:     partition1_control <= ppc_pstate_t'(w_data[1:0]);
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Per-port registers and retrain sequencers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : g_port
      // Port control write attaches or disables the port
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          port_control[g] <= '{mode: PPC_MODE_UNATT, partition_select: 4'h0, action: 2'b00}; // RULE2
          power_mgmt_capability[g] <= 8'h00;
          virtual_channel_capability_header[g] <= 12'h000;
          retrain_go[g] <= 1'b0;
        end else begin
          retrain_go[g] <= 1'b0;
          if (wr_fire && wr_ok && port_idx(aw_addr) == 4'(g)) begin
            case (aw_addr[11:8])
              4'h2: begin
                port_control[g].mode   <= ppc_mode_t'(w_data[`PPC_MODE_LSB +: 4]); // RULE5
                port_control[g].action <= w_data[`PPC_OMA_LSB +: 2];
                if (ppc_mode_t'(w_data[`PPC_MODE_LSB +: 4]) != PPC_MODE_DIS) begin
                  port_control[g].partition_select <= w_data[`PPC_PARTITION_SELECT_LSB +: 4]; // RULE5
                end // Disabled mode keeps old selection: RULE8
              end
              4'h3: retrain_go[g] <= w_data[`PPC_RETRAIN_BIT]; // RULE6
              4'h4: power_mgmt_capability[g] <= w_data[`PPC_NXT_LSB +: 8];
              4'h5: virtual_channel_capability_header[g] <= w_data[`PPC_VCNXT_LSB +: 12];
              default: ;
            endcase
          end
        end
      end

      ppc_retrain u_rt (
        .clock     (clock),
        .rst_b     (rst_b),
        .start     (retrain_go[g]),
        .in_detect (retrain_det[g]),
        .busy      (retrain_busy[g])
      );

      // Link control: disabled ports drop enable regardless of partition
      always_comb begin
        port_link[g].retrain  = retrain_det[g]; // RULE6
        port_link[g].enable   = (port_control[g].mode == PPC_MODE_DOWN ||
                                 port_control[g].mode == PPC_MODE_UP); // RULE8
        port_link[g].upstream = (port_control[g].mode == PPC_MODE_UP);
        port_link[g].partition_select     = port_link[g].enable ? port_control[g].partition_select : 4'h0; // RULE8
      end
    end
  endgenerate

  assign partition_active = {partition1_control == PPC_PARTITION_SELECT_ACTIVE,
                             partition0_control == PPC_PARTITION_SELECT_ACTIVE};
  assign partition_reset_input_n_en = gpio_alt;

  // ----------------------------------------
  // AXI read channel
  // ----------------------------------------
  logic [31:0] rd_val;   // Selected read word
  logic [3:0]  rp;       // Read port index
  // Read mux shows state of timers, partitions, ports and retrain
  always_comb begin
    rp     = port_idx(s_axi_araddr);
    rd_val = 32'h0000_0000;
    case (s_axi_araddr[11:8])
      4'h0: begin
        case (s_axi_araddr)
          `PPC_OFS_SIDE_DLY:  rd_val = side_effect_delay_timer;
          `PPC_OFS_MODE_DLY:  rd_val = mode_change_drain_delay_timer;
          `PPC_OFS_DRAIN_DLY: rd_val = reset_drain_delay_timer;
          `PPC_OFS_USBR_DLY:  rd_val = upstream_bus_reset_delay_timer;
          `PPC_OFS_LOAD_CTL:  rd_val = {31'h0, load_done};
          `PPC_OFS_STATUS:    rd_val = {26'h0, boot_switch_mode == `PPC_BOOT_MULTI_EE,
                                        fund_reset_active, |retrain_busy, 1'b0, partition_active};
          `PPC_OFS_GPIO_ALT:  rd_val = {31'h0, gpio_alt};
          default: rd_val = 32'h0000_0000;
        endcase
      end
      4'h1: rd_val = {30'h0, s_axi_araddr[2] ? partition1_control : partition0_control};
      4'h2: rd_val = {22'h0, port_control[rp].action, port_control[rp].partition_select, port_control[rp].mode};
      4'h3: rd_val = {30'h0, retrain_det[rp], retrain_busy[rp]};
      4'h4: rd_val = {16'h0, power_mgmt_capability[rp], 8'h01};
      4'h5: rd_val = {virtual_channel_capability_header[rp], 20'h10002};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // One-cycle read answer held until taken
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= mapped(s_axi_araddr) ? rd_val : 32'h0000_0000;
      s_axi_rresp  <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> src/ppc_cfg.svh
// Constants of the partition and port configuration loader.
// Assumes AXI4-Lite with 32-bit data, one aligned word per register.
// Contract
// RULE1: Static configuration applies only during fundamental reset
// RULE2: Boot mode 0xD starts partitions disabled, ports unattached
// RULE3: Loader first clears all four delay timers
// RULE4: Loader sets each used partition Active
// RULE5: Port control write attaches port to partition
// RULE6: Full link retrain restarts link from Detect
// RULE7: Downstream ports first with retrain, then upstream
// RULE8: Disabled mode disables port, ignores partition select
// RULE9: Loader chains capability lists on upstream ports
// RULE10: Loader enables partition reset input pin function
// RULE11: Loader finally restores the four delay timers
// RULE12: Load finishes within one second after reset
// RULE13: Loader writes strictly in order, one at a time
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PPC_OFS_SIDE_DLY   12'h000
`define PPC_OFS_MODE_DLY   12'h004
`define PPC_OFS_DRAIN_DLY  12'h008
`define PPC_OFS_USBR_DLY   12'h00c
`define PPC_OFS_LOAD_CTL   12'h010
`define PPC_OFS_STATUS     12'h014
`define PPC_OFS_GPIO_ALT   12'h018
`define PPC_OFS_PART0      12'h100
`define PPC_OFS_PART1      12'h104
`define PPC_OFS_PORT_BASE  12'h200
`define PPC_OFS_PHY_BASE   12'h300
`define PPC_OFS_POWER_MGMT_CAPABILITY_BASE 12'h400
`define PPC_OFS_VCCAP_BASE 12'h500

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define PPC_MODE_LSB      0
`define PPC_PARTITION_SELECT_LSB      4
`define PPC_OMA_LSB       8
`define PPC_RETRAIN_BIT   0
`define PPC_NXT_LSB       8
`define PPC_VCNXT_LSB     20
`define PPC_LOAD_DONE_BIT 0
`define PPC_BOOT_MULTI_EE 4'hd

// ----------------------------------------
// Reset values and Detect hold count
// ----------------------------------------
`define PPC_RST_SIDE_DLY  32'h0000_0064
`define PPC_RST_MODE_DLY  32'h0000_0064
`define PPC_RST_DRAIN_DLY 32'h0000_0064
`define PPC_RST_USBR_DLY  32'h0000_0064
`define PPC_RETRAIN_CYC   8'h04

`endif

// >>> src/ppc_pkg.sv
// Types of the partition and port configuration loader.
// Assumes ppc_cfg.svh for numbers.
package ppc_pkg;
  // Port operating modes
  typedef enum logic [3:0] {
    PPC_MODE_UNATT = 4'h0,
    PPC_MODE_DOWN  = 4'h1,
    PPC_MODE_UP    = 4'h2,
    PPC_MODE_DIS   = 4'h3
  } ppc_mode_t;
  // Partition states
  typedef enum logic [1:0] {
    PPC_PARTITION_SELECT_DIS    = 2'h0,
    PPC_PARTITION_SELECT_ACTIVE = 2'h1
  } ppc_pstate_t;
  // One port's static view
  typedef struct packed {
    ppc_mode_t   mode;
    logic [3:0]  partition_select;
    logic [1:0]  action;
  } ppc_port_t;
  // Per-port link stimulus to the link layer
  typedef struct packed {
    logic        retrain;
    logic        enable;
    logic        upstream;
    logic [3:0]  partition_select;
  } ppc_link_t;
endpackage

// >>> src/ppc_retrain.sv
// Per-port retrain sequencer: forces Detect then releases.
// Assumes one clock and a start pulse from the register file.
`timescale 1ns/100ps
`default_nettype none
`include "ppc_cfg.svh"
module ppc_retrain (
  input  wire logic clock,       // Core clock
  input  wire logic rst_b,       // Async reset, active low
  input  wire logic start,       // Retrain request pulse
  output logic      in_detect,   // Port held in Detect
  output logic      busy         // Retrain under way
);
  import ppc_pkg::*;

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [1:0] {
    PPC_RT_IDLE = 2'b01,
    PPC_RT_DET  = 2'b10
  } ppc_rt_t;

  ppc_rt_t    state;   // Sequencer state
  logic [7:0] count;   // Detect hold counter

  // Hold Detect a few cycles so the link layer sees it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= PPC_RT_IDLE;
      count <= 8'h00;
    end else begin
      case (state)
        PPC_RT_IDLE: begin
          if (start) begin
            state <= PPC_RT_DET; // RULE6
            count <= `PPC_RETRAIN_CYC;
          end
        end
        PPC_RT_DET: begin
          if (count == 8'h01) begin
            state <= PPC_RT_IDLE;
          end
          count <= count - 8'h01;
        end
        default: state <= PPC_RT_IDLE;
      endcase
    end
  end

  assign in_detect = (state == PPC_RT_DET);
  assign busy      = (state == PPC_RT_DET);
endmodule
`default_nettype wire

// >>> verif/ppc_master.sv
// Loader model: AXI4-Lite master standing in for the EEPROM or SMBus writer.
// Assumes one clock; inputs of the slave change only just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module ppc_master (
  input  wire logic        clock,         // Core clock
  output logic [11:0]      s_axi_awaddr,  // Write address
  output logic             s_axi_awvalid, // Write address valid
  input  wire logic        s_axi_awready, // Write address ready
  output logic [31:0]      s_axi_wdata,   // Write data
  output logic [3:0]       s_axi_wstrb,   // Whole words only
  output logic             s_axi_wvalid,  // Write data valid
  input  wire logic        s_axi_wready,  // Write data ready
  input  wire logic [1:0]  s_axi_bresp,   // Write response
  input  wire logic        s_axi_bvalid,  // Write response valid
  output logic             s_axi_bready,  // Write response ready
  output logic [11:0]      s_axi_araddr,  // Read address
  output logic             s_axi_arvalid, // Read address valid
  input  wire logic        s_axi_arready, // Read address ready
  input  wire logic [31:0] s_axi_rdata,   // Read data
  input  wire logic [1:0]  s_axi_rresp,   // Read response
  input  wire logic        s_axi_rvalid,  // Read data valid
  output logic             s_axi_rready   // Read data ready
);
  // Idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // One write; ready is looked at in the low half so the edge itself is race free
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge clock);
      aw_ok = aw_ok || (s_axi_awvalid && s_axi_awready);
      w_ok  = w_ok || (s_axi_wvalid && s_axi_wready);
      @(posedge clock);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    do @(negedge clock); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask
  // One read; nothing else is started before the data returns
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(negedge clock); while (!s_axi_arready);
    @(posedge clock);
    s_axi_arvalid <= 1'b0;
    do @(negedge clock); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verif/ppc_loader_asserts.sv
// Checker for the configuration loader, bound to its ports.
// Assumes one clock domain and writes offered whole on both channels.
`timescale 1ns/100ps
`default_nettype none
module ppc_loader_asserts #(
  parameter int NPORTS = 16  // Number of switch ports
) (
  input wire logic                           clock,
  input wire logic                           rst_b,
  input wire logic [3:0]                     boot_switch_mode,
  input wire logic                           fund_reset_active,
  input wire logic [11:0]                    s_axi_awaddr,
  input wire logic                           s_axi_awvalid,
  input wire logic                           s_axi_awready,
  input wire logic [31:0]                    s_axi_wdata,
  input wire logic                           s_axi_wvalid,
  input wire logic                           s_axi_wready,
  input wire logic [1:0]                     s_axi_bresp,
  input wire logic                           s_axi_bvalid,
  input wire ppc_pkg::ppc_link_t [NPORTS-1:0] port_link,
  input wire logic [1:0]                     partition_active
);
  import ppc_pkg::*;
  logic       take;   // Address and data taken at one edge
  logic       any_rt; // Some port held in Detect
  logic [3:0] idx;    // Port of the last write
  logic [3:0] fld;    // Partition field of the last write
  assign take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Retrain is judged over all ports: the port index moves on with the next write
  always_comb begin
    any_rt = 1'b0;
    for (int i = 0; i < NPORTS; i++) any_rt = any_rt | port_link[i].retrain;
  end
  // Remember which port the last write aimed at
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      idx <= 4'h0;
      fld <= 4'h0;
    end else if (take) begin
      idx <= s_axi_awaddr[5:2];
      fld <= s_axi_wdata[7:4];
    end
  end
  default clocking dcb @(posedge clock); endclocking
  default disable iff (!rst_b);
  reset_clean_a: assert property (
    !$past(rst_b) && boot_switch_mode == 4'hd |-> partition_active == 2'h0
      && !port_link[0].enable && !port_link[NPORTS-1].enable) else $error("not clean after reset");
  window_shut_a: assert property (
    take && !fund_reset_active |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h2) else $error("write outside window");
  frozen_state_a: assert property (
    !fund_reset_active && !$past(fund_reset_active) |-> $stable(port_link) && $stable(partition_active))
    else $error("state moved outside window");
  port_attach_a: assert property (
    take && fund_reset_active && s_axi_awaddr[11:8] == 4'h2 && s_axi_wdata[3:0] inside {4'h1, 4'h2}
    |-> ##2 port_link[idx].enable && port_link[idx].partition_select == fld && port_link[idx].upstream == $past(s_axi_wdata[1], 2))
    else $error("port not attached");
  retrain_run_a: assert property (
    take && fund_reset_active && s_axi_awaddr[11:8] == 4'h3 && s_axi_wdata[0]
    |-> ##3 any_rt [*4] ##1 !any_rt) else $error("retrain pulse wrong");
  port_off_a: assert property (
    take && fund_reset_active && s_axi_awaddr[11:8] == 4'h2 && s_axi_wdata[3:0] == 4'h3
    |-> ##2 !port_link[idx].enable && port_link[idx].partition_select == 4'h0) else $error("port not disabled");
  cover property (take && !fund_reset_active);
  cover property (partition_active == 2'h3);
  cover property ($rose(any_rt));
endmodule
bind ppc_loader ppc_loader_asserts #(.NPORTS(NPORTS)) i_chk (
  .clock(clock), .rst_b(rst_b), .boot_switch_mode(boot_switch_mode), .fund_reset_active(fund_reset_active),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .port_link(port_link),
  .partition_active(partition_active)
);
`default_nettype wire

// >>> verif/ppc_loader_test.sv
// Bench for the configuration loader: plays the two-partition load sequence.
// Assumes ppc_master as the loader and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`include "ppc_cfg.svh"
module ppc_loader_test;
  import ppc_pkg::*;
  logic              clock, rst_b, fund_reset_active, partition_reset_input_n_en;
  logic [3:0]        boot_switch_mode, s_axi_wstrb, md, pt;
  logic [11:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd_data;
  logic [1:0]        s_axi_bresp, s_axi_rresp, resp, partition_active;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  ppc_link_t [15:0]  port_link;
  int                failures, compares, pn;
  time               t0;   // Time of reset release
  int                pl[6] = '{1, 2, 4, 5, 0, 3}; // Downstream ports first, then upstream
  logic [31:0]       dflt[4] = '{`PPC_RST_SIDE_DLY, `PPC_RST_MODE_DLY, `PPC_RST_DRAIN_DLY, `PPC_RST_USBR_DLY};
  ppc_loader #(.NPORTS(16)) i_dut (
    .clock(clock), .rst_b(rst_b), .boot_switch_mode(boot_switch_mode), .fund_reset_active(fund_reset_active),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port_link(port_link), .partition_active(partition_active),
    .partition_reset_input_n_en(partition_reset_input_n_en));
  ppc_master i_mst (
    .clock(clock), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write and expect a response code
  task automatic wrc(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    i_mst.wr(a, d, resp);
    check({30'h0, resp}, {30'h0, er});
  endtask
  // Read and expect a value
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    i_mst.rd(a, rd_data, resp);
    check(rd_data, e);
  endtask
  // Verdict and end of run
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // 20 MHz core clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Hang guard, far above the few hundred cycles the sequence needs
  initial begin
    #2000000;
    failures++;
    wrap_up();
  end
  // Main sequence
  initial begin
    rst_b = 1'b0;
    fund_reset_active = 1'b1;
    boot_switch_mode = `PPC_BOOT_MULTI_EE;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    t0 = $time;
    @(negedge clock);
    check({30'h0, partition_active}, 32'h0);
    for (int p = 0; p < 16; p++) check({31'h0, port_link[p].enable}, 32'h0);
    for (int t = 0; t < 4; t++) rdc(12'(4 * t), dflt[t]);
    for (int t = 0; t < 4; t++) wrc(12'(4 * t), 32'h0, 2'h0);
    for (int t = 0; t < 4; t++) rdc(12'(4 * t), 32'h0);
    wrc(`PPC_OFS_PART0, 32'h1, 2'h0);
    wrc(`PPC_OFS_PART1, 32'h1, 2'h0);
    @(negedge clock);
    check({30'h0, partition_active}, 32'h3);
    for (int i = 0; i < 6; i++) begin
      pn = pl[i];
      md = (i < 4) ? 4'h1 : 4'h2;
      pt = (pn >= 3) ? 4'h1 : 4'h0;
      wrc(12'h200 + 12'(4 * pn), {24'h0, pt, md}, 2'h0);
      @(negedge clock);
      check({26'h0, port_link[pn][5:0]}, {26'h0, 1'b1, md == 4'h2, pt});
      if (i < 4) begin
        wrc(12'h300 + 12'(4 * pn), 32'h1, 2'h0);
        @(negedge clock);
        check({31'h0, port_link[pn].retrain}, 32'h1);
      end
    end
    for (int p = 6; p < 16; p++) begin
      wrc(12'h200 + 12'(4 * p), 32'h0000_00f3, 2'h0);
      @(negedge clock);
      check({26'h0, port_link[p][5:0]}, 32'h0);
      rdc(12'h200 + 12'(4 * p), 32'h0000_0003);
    end
    for (int u = 0; u < 4; u += 3) begin
      wrc(12'h400 + 12'(4 * u), 32'h0000_4800, 2'h0);
      wrc(12'h500 + 12'(4 * u), 32'h1000_0000, 2'h0);
      i_mst.rd(12'h400 + 12'(4 * u), rd_data, resp);
      check(rd_data & 32'h0000_ff00, 32'h0000_4800);
      i_mst.rd(12'h500 + 12'(4 * u), rd_data, resp);
      check(rd_data & 32'hfff0_0000, 32'h1000_0000);
    end
    wrc(`PPC_OFS_GPIO_ALT, 32'h1, 2'h0);
    @(negedge clock);
    check({31'h0, partition_reset_input_n_en}, 32'h1);
    for (int t = 0; t < 4; t++) wrc(12'(4 * t), dflt[t], 2'h0);
    for (int t = 0; t < 4; t++) rdc(12'(4 * t), dflt[t]);
    rdc(`PPC_OFS_STATUS, 32'h0000_0033);
    check({31'h0, ($time - t0) < 64'd1_000_000_000}, 32'h1);
    rdc(12'h600, 32'h0);
    check({30'h0, resp}, 32'h2);
    wrc(12'h600, 32'h1, 2'h2);
    @(posedge clock);
    fund_reset_active <= 1'b0;
    wrc(`PPC_OFS_PART0, 32'h0, 2'h2);
    wrc(12'h204, 32'h0000_0003, 2'h2);
    @(negedge clock);
    check({30'h0, partition_active}, 32'h3);
    check({26'h0, port_link[1][5:0]}, 32'h20);
    wrap_up();
  end
endmodule
`default_nettype wire
